/* File: design/bcd_calendar_rtc.sv */
`timescale 1ns/1ns
// Contract
// - Seconds are BCD tens 0-5, units 0-9.
// - Minutes are BCD tens 0-5, bit 7 zero.
// - Hours tens 0-2, units, bit 6 zero.
// - Hour bit 7 is afternoon in 12-hour mode.
// - Day of month BCD, resets to 01.
// - Month BCD 01 to 12, resets to 01.
// - Year two BCD digits, resets to 00.
// - Weekday 0 to 6, resets to zero.
// - Alarm set mirrors time fields except weekday and resets.
// - Snapshot copies time into read latches.
// - Snapshot bit self-clears, reads zero.
// - Rounding at next second, reads one until done.
// - Load bit presets prescaler from compensation value.
// - Hour format switchable anytime, reads follow it.
// - Auto compensation enable, resets off.
// - Test mode compensates every prescaler end when auto compensation is on.
// - Run bit controls counting, status shows state.
// - Alarm flag holds interrupt low until cleared.
// - Power-up flag set by reset, write-one clears.
// - Status shows day, hour, minute, second elapsed.
// - Alarm interrupt enable, resets off.
// - Periodic interrupt enable and period select.
module bcd_calendar_rtc #(
  parameter int TICKS_PER_SEC = rtc_pkg::OSC_TICKS_PER_SEC
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Oscillator from the pin.
  input  wire logic       osc_32k,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // Event outputs.
  output logic            alarm_irq_n,
  output logic            periodic_irq
);
  // ************************************************************
  // Parameter checks and helpers.
  // ************************************************************
  if (TICKS_PER_SEC < 2 || TICKS_PER_SEC > 65536) begin : g_chk
    $error("TICKS_PER_SEC out of range");
  end

  localparam logic [16:0] CNT_END = 17'(TICKS_PER_SEC - 1);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  function automatic logic [5:0] month_days(input logic [4:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: month_days = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 6'h30;
      default: month_days = 6'h31;
    endcase
  endfunction : month_days

  function automatic logic [5:0] bin_to_bcd(input logic [4:0] b);
    if (b >= 5'd20) begin
      bin_to_bcd = {2'h2, 4'(b - 5'd20)};
    end else if (b >= 5'd10) begin
      bin_to_bcd = {2'h1, 4'(b - 5'd10)};
    end else begin
      bin_to_bcd = {2'h0, b[3:0]};
    end
  endfunction : bin_to_bcd

  function automatic logic [4:0] bcd_to_bin(input logic [5:0] v);
    bcd_to_bin = ({3'h0, v[5:4]} * 5'd10) + {1'b0, v[3:0]};
  endfunction : bcd_to_bin

  // Hours are kept in binary 24-hour form; the format is applied at
  // the port so that switching modes never disturbs the count.
  function automatic logic [7:0] hour_out(input logic [4:0] h,
                                          input logic m12);
    logic [4:0] h12;
    h12 = (h == 5'd0) ? 5'd12 : (h > 5'd12) ? 5'(h - 5'd12) : h;
    if (m12) begin
      hour_out = {h >= 5'd12, 1'b0, bin_to_bcd(h12)};
    end else begin
      hour_out = {2'b00, bin_to_bcd(h)};
    end
  endfunction : hour_out

  function automatic logic [4:0] hour_in(input logic [7:0] d,
                                         input logic m12);
    logic [4:0] hb;
    hb = bcd_to_bin(d[5:0]);
    if (m12) begin
      hour_in = 5'((hb == 5'd12 ? 5'd0 : hb)
                   + (d[rtc_pkg::HOUR_PM] ? 5'd12 : 5'd0));
    end else begin
      hour_in = hb;
    end
  endfunction : hour_in

  // ************************************************************
  // State.
  // ************************************************************
  logic [6:0]  sec, min, a_sec, a_min, next_sec, next_min;
  logic [4:0]  hr, a_hr, next_hr, mon, a_mon, next_mon;
  logic [5:0]  day, a_day, next_day;
  logic [7:0]  yr, a_yr, next_yr, wday, next_wday;
  logic [6:0]  s_sec, s_min;
  logic [4:0]  s_hr, s_mon;
  logic [5:0]  s_day;
  logic [7:0]  s_yr, s_wday, ctrl_sel, irq_en, rd_val;
  logic [15:0] comp;
  logic [16:0] cnt;
  logic        snap_valid, round_req, running, alarm_flag, power_up;
  logic        match, match_q, osc_s1, osc_s2, osc_s3, osc_tick;
  logic        sec_tick, ev_m, ev_h, ev_d, carry_mo;
  logic [3:0]  ev_bits;
  logic [2:0]  ctrl_mode;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // Oscillator synchroniser and prescaler.
  // ************************************************************
  // The pin passes three flops; the second and third feed the edge detect.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_32k;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end
  assign osc_tick = osc_s2 & ~osc_s3;
  assign sec_tick = running & osc_tick & (cnt == CNT_END);

  // Running follows the run bit at the next oscillator edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else if (osc_tick) begin
      running <= ctrl_sel[rtc_pkg::CTRL_RUN];
    end
  end

  // A signed start value stretches or shortens one second.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 17'h00000;
    end else if (reg_wr_en && reg_addr == rtc_pkg::OFF_CTRL
                 && reg_wdata[rtc_pkg::CTRL_LOAD32]) begin
      cnt <= {comp[15], comp};
    end else if (sec_tick) begin
      if (ctrl_sel[rtc_pkg::CTRL_AUTOCOMP]
          && (ctrl_mode[1] || ev_h)) begin
        cnt <= {comp[15], comp};
      end else begin
        cnt <= 17'h00000;
      end
    end else if (running && osc_tick) begin
      cnt <= 17'(cnt + 17'h00001);
    end
  end

  // ************************************************************
  // Carry chain.
  // ************************************************************
  always_comb begin
    next_sec  = sec;
    next_min  = min;
    next_hr   = hr;
    next_day  = day;
    next_mon  = mon;
    next_yr   = yr;
    next_wday = wday;
    ev_m      = 1'b0;
    ev_h      = 1'b0;
    ev_d      = 1'b0;
    carry_mo  = 1'b0;
    if (sec_tick) begin
      if (round_req) begin
        next_sec = 7'h00;
        ev_m     = (sec >= 7'h30);
      end else if (sec == 7'h59) begin
        next_sec = 7'h00;
        ev_m     = 1'b1;
      end else begin
        next_sec = 7'(bcd_inc({1'b0, sec}));
      end
      if (ev_m) begin
        ev_h     = (min == 7'h59);
        next_min = ev_h ? 7'h00 : 7'(bcd_inc({1'b0, min}));
      end
      if (ev_h) begin
        ev_d    = (hr == 5'd23);
        next_hr = ev_d ? 5'd0 : 5'(hr + 5'd1);
      end
      if (ev_d) begin
        next_wday[2:0] = (wday[2:0] == 3'd6) ? 3'd0
                         : 3'(wday[2:0] + 3'd1);
        carry_mo = (day == month_days(mon, yr));
        next_day = carry_mo ? 6'h01 : 6'(bcd_inc({2'b00, day}));
      end
      if (carry_mo) begin
        next_mon = (mon == 5'h12) ? 5'h01
                   : 5'(bcd_inc({3'b000, mon}));
        if (mon == 5'h12) begin
          // Year 99 wraps to 00, so the tens digit never passes 9.
          next_yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
        end
      end
    end
  end

  // ************************************************************
  // Time and calendar registers.
  // ************************************************************
  // A host write to a field wins over the tick in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec  <= 7'h00;
      min  <= 7'h00;
      hr   <= 5'd0;
      day  <= 6'(rtc_pkg::RST_ONE);
      mon  <= 5'(rtc_pkg::RST_ONE);
      yr   <= 8'h00;
      wday <= 8'h00;
    end else begin
      sec  <= (reg_wr_en && reg_addr == rtc_pkg::OFF_SEC)
              ? reg_wdata[6:0] : next_sec;
      min  <= (reg_wr_en && reg_addr == rtc_pkg::OFF_MIN)
              ? reg_wdata[6:0] : next_min;
      hr   <= (reg_wr_en && reg_addr == rtc_pkg::OFF_HOUR)
              ? hour_in(reg_wdata, ctrl_mode[0]) : next_hr;
      day  <= (reg_wr_en && reg_addr == rtc_pkg::OFF_DAY)
              ? reg_wdata[5:0] : next_day;
      mon  <= (reg_wr_en && reg_addr == rtc_pkg::OFF_MONTH)
              ? reg_wdata[4:0] : next_mon;
      yr   <= (reg_wr_en && reg_addr == rtc_pkg::OFF_YEAR)
              ? reg_wdata : next_yr;
      wday <= (reg_wr_en && reg_addr == rtc_pkg::OFF_WDAY)
              ? {reg_wdata[7:3], reg_wdata[2:0] > 3'd6 ? 3'd6
                 : reg_wdata[2:0]} : next_wday;
    end
  end

  // Alarm set; hours are converted from the current format.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_sec <= 7'h00;
      a_min <= 7'h00;
      a_hr  <= 5'd0;
      a_day <= 6'(rtc_pkg::RST_ONE);
      a_mon <= 5'(rtc_pkg::RST_ONE);
      a_yr  <= 8'h00;
    end else if (reg_wr_en) begin
      case (reg_addr)
        rtc_pkg::OFF_A_SEC:  a_sec <= reg_wdata[6:0];
        rtc_pkg::OFF_A_MIN:  a_min <= reg_wdata[6:0];
        rtc_pkg::OFF_A_HOUR: a_hr  <= hour_in(reg_wdata, ctrl_mode[0]);
        rtc_pkg::OFF_A_DAY:  a_day <= reg_wdata[5:0];
        rtc_pkg::OFF_A_MON:  a_mon <= reg_wdata[4:0];
        rtc_pkg::OFF_A_YEAR: a_yr  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Snapshot latches.
  // ************************************************************
  // Reads come from the latches until the host rewrites the time.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {s_sec, s_min, s_hr, s_day, s_mon, s_yr, s_wday} <= '0;
      snap_valid <= 1'b0;
    end else if (reg_wr_en && reg_addr == rtc_pkg::OFF_CTRL
                 && reg_wdata[rtc_pkg::CTRL_SNAP]) begin
      {s_sec, s_min, s_hr, s_day, s_mon, s_yr, s_wday}
        <= {sec, min, hr, day, mon, yr, wday};
      snap_valid <= 1'b1;
    end else if (reg_wr_en && reg_addr >= rtc_pkg::OFF_SEC
                 && reg_addr <= rtc_pkg::OFF_WDAY) begin
      snap_valid <= 1'b0;
    end
  end

  // ************************************************************
  // Control, compensation and interrupt enable.
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sel  <= 8'h00;
      ctrl_mode <= 3'b000;
      round_req <= 1'b0;
      comp      <= 16'h0000;
      irq_en    <= 8'h00;
    end else begin
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_CTRL) begin
        ctrl_sel[rtc_pkg::CTRL_RUN]      <= reg_wdata[rtc_pkg::CTRL_RUN];
        ctrl_sel[rtc_pkg::CTRL_AUTOCOMP] <=
          reg_wdata[rtc_pkg::CTRL_AUTOCOMP];
        ctrl_mode <= {1'b0, reg_wdata[rtc_pkg::CTRL_TEST],
                      reg_wdata[rtc_pkg::CTRL_MODE12]};
      end
      // A write of one arms rounding; the next second tick clears it.
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_CTRL
          && reg_wdata[rtc_pkg::CTRL_ROUND]) begin
        round_req <= 1'b1;
      end else if (sec_tick) begin
        round_req <= 1'b0;
      end
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_COMP_L) begin
        comp[7:0] <= reg_wdata;
      end
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_COMP_H) begin
        comp[15:8] <= reg_wdata;
      end
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_IRQ_EN) begin
        irq_en <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // Status flags and event outputs.
  // ************************************************************
  assign match = (sec == a_sec) && (min == a_min) && (hr == a_hr)
                 && (day == a_day) && (mon == a_mon) && (yr == a_yr);

  // A new alarm edge wins over a write-one clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_up     <= 1'b1;
      alarm_flag   <= 1'b0;
      match_q      <= 1'b0;
      ev_bits      <= 4'h0;
      alarm_irq_n  <= 1'b1;
      periodic_irq <= 1'b0;
    end else begin
      match_q <= match;
      if (reg_wr_en && reg_addr == rtc_pkg::OFF_STAT
          && reg_wdata[rtc_pkg::STAT_PWRUP]) begin
        power_up <= 1'b0;
      end
      if (irq_en[rtc_pkg::IRQ_ALARM_EN] && match && !match_q) begin
        alarm_flag <= 1'b1;
      end else if (reg_wr_en && reg_addr == rtc_pkg::OFF_STAT
                   && reg_wdata[rtc_pkg::STAT_ALARM]) begin
        alarm_flag <= 1'b0;
      end
      alarm_irq_n <= ~alarm_flag;
      if (sec_tick) begin
        ev_bits <= {ev_d, ev_h, ev_m, 1'b1};
      end
      case (irq_en[1:0])
        2'd0: periodic_irq <= irq_en[rtc_pkg::IRQ_TIMER_EN] & sec_tick;
        2'd1: periodic_irq <= irq_en[rtc_pkg::IRQ_TIMER_EN] & ev_m;
        2'd2: periodic_irq <= irq_en[rtc_pkg::IRQ_TIMER_EN] & ev_h;
        default: periodic_irq <= irq_en[rtc_pkg::IRQ_TIMER_EN] & ev_d;
      endcase
    end
  end

  // ************************************************************
  // Read path.
  // ************************************************************
  always_comb begin
    case (reg_addr)
      rtc_pkg::OFF_SEC:   rd_val = {1'b0, snap_valid ? s_sec : sec};
      rtc_pkg::OFF_MIN:   rd_val = {1'b0, snap_valid ? s_min : min};
      rtc_pkg::OFF_HOUR:  rd_val = hour_out(snap_valid ? s_hr : hr,
                                            ctrl_mode[0]);
      rtc_pkg::OFF_DAY:   rd_val = {2'b00, snap_valid ? s_day : day};
      rtc_pkg::OFF_MONTH: rd_val = {3'b000, snap_valid ? s_mon : mon};
      rtc_pkg::OFF_YEAR:  rd_val = snap_valid ? s_yr : yr;
      rtc_pkg::OFF_WDAY:  rd_val = snap_valid ? s_wday : wday;
      rtc_pkg::OFF_A_SEC:  rd_val = {1'b0, a_sec};
      rtc_pkg::OFF_A_MIN:  rd_val = {1'b0, a_min};
      rtc_pkg::OFF_A_HOUR: rd_val = hour_out(a_hr, ctrl_mode[0]);
      rtc_pkg::OFF_A_DAY:  rd_val = {2'b00, a_day};
      rtc_pkg::OFF_A_MON:  rd_val = {3'b000, a_mon};
      rtc_pkg::OFF_A_YEAR: rd_val = a_yr;
      rtc_pkg::OFF_CTRL:  rd_val = {3'b000, ctrl_mode[1:0],
                                    ctrl_sel[rtc_pkg::CTRL_AUTOCOMP],
                                    round_req,
                                    ctrl_sel[rtc_pkg::CTRL_RUN]};
      rtc_pkg::OFF_STAT:  rd_val = {power_up, alarm_flag, ev_bits,
                                    running, 1'b0};
      rtc_pkg::OFF_IRQ_EN: rd_val = irq_en;
      rtc_pkg::OFF_COMP_L: rd_val = comp[7:0];
      rtc_pkg::OFF_COMP_H: rd_val = comp[15:8];
      default:            rd_val = 8'h00;
    endcase
  end

  // Read data is registered and valid one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rdata    <= reg_rd_en ? rd_val : reg_rdata;
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence s_status_w1c(int b);
    reg_wr_en && reg_addr == rtc_pkg::OFF_STAT && reg_wdata[b];
  endsequence

  property p_sec_range;
    sec[6:4] <= 3'd5 && sec[3:0] <= 4'd9;
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("seconds out of range");

  property p_min_hr_range;
    min[6:4] <= 3'd5 && min[3:0] <= 4'd9 && hr <= 5'd23;
  endproperty
  a_min_hr_range: assert property (p_min_hr_range)
    else $error("minutes or hours out of range");

  property p_wday_range;
    wday[2:0] <= 3'd6;
  endproperty
  a_wday_range: assert property (p_wday_range)
    else $error("weekday out of range");

  property p_round_done;
    sec_tick && round_req |=> sec == 7'h00 && !round_req;
  endproperty
  a_round_done: assert property (p_round_done)
    else $error("rounding not finished at second tick");

  property p_irq_follows;
    alarm_flag |=> !alarm_irq_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("alarm interrupt not low while flag set");

  property p_pwrup_clear;
    $fell(power_up) |-> $past(reg_wr_en && reg_addr == rtc_pkg::OFF_STAT
                              && reg_wdata[rtc_pkg::STAT_PWRUP]);
  endproperty
  a_pwrup_clear: assert property (p_pwrup_clear)
    else $error("power-up flag cleared without write");

  property p_alarm_set;
    irq_en[rtc_pkg::IRQ_ALARM_EN] && match && !match_q
      |=> alarm_flag ##1 !alarm_irq_n;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm match did not raise flag");

  property p_alarm_w1c;
    s_status_w1c(rtc_pkg::STAT_ALARM)
      ##0 !(irq_en[rtc_pkg::IRQ_ALARM_EN] && match && !match_q)
      |=> !alarm_flag ##1 alarm_irq_n;
  endproperty
  a_alarm_w1c: assert property (p_alarm_w1c)
    else $error("alarm flag not cleared by write");

  property p_load32;
    reg_wr_en && reg_addr == rtc_pkg::OFF_CTRL
      && reg_wdata[rtc_pkg::CTRL_LOAD32] |=> cnt == {comp[15], comp};
  endproperty
  a_load32: assert property (p_load32)
    else $error("prescaler not loaded from compensation");

  property p_frozen;
    !running && !reg_wr_en |=> $stable(sec) && $stable(min);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("time moved while frozen");

  property p_snap_zero;
    reg_rd_en && reg_addr == rtc_pkg::OFF_CTRL
      |=> reg_rd_valid && !reg_rdata[rtc_pkg::CTRL_SNAP];
  endproperty
  a_snap_zero: assert property (p_snap_zero)
    else $error("snapshot bit read back as one");
endmodule : bcd_calendar_rtc

/* File: design/rtc_pkg.sv */
package rtc_pkg;
  // ************************************************************
  // Register offsets on the register port.
  // ************************************************************
  localparam logic [7:0] OFF_SEC    = 8'h1c;
  localparam logic [7:0] OFF_MIN    = 8'h1d;
  localparam logic [7:0] OFF_HOUR   = 8'h1e;
  localparam logic [7:0] OFF_DAY    = 8'h1f;
  localparam logic [7:0] OFF_MONTH  = 8'h20;
  localparam logic [7:0] OFF_YEAR   = 8'h21;
  localparam logic [7:0] OFF_WDAY   = 8'h22;
  localparam logic [7:0] OFF_A_SEC  = 8'h23;
  localparam logic [7:0] OFF_A_MIN  = 8'h24;
  localparam logic [7:0] OFF_A_HOUR = 8'h25;
  localparam logic [7:0] OFF_A_DAY  = 8'h26;
  localparam logic [7:0] OFF_A_MON  = 8'h27;
  localparam logic [7:0] OFF_A_YEAR = 8'h28;
  localparam logic [7:0] OFF_CTRL   = 8'h29;
  localparam logic [7:0] OFF_STAT   = 8'h2a;
  localparam logic [7:0] OFF_IRQ_EN = 8'h2b;
  localparam logic [7:0] OFF_COMP_L = 8'h2c;
  localparam logic [7:0] OFF_COMP_H = 8'h2d;
  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_ROUND    = 1;
  localparam int CTRL_AUTOCOMP = 2;
  localparam int CTRL_MODE12   = 3;
  localparam int CTRL_TEST     = 4;
  localparam int CTRL_LOAD32   = 5;
  localparam int CTRL_SNAP     = 6;
  localparam int STAT_RUN      = 1;
  localparam int STAT_ALARM    = 6;
  localparam int STAT_PWRUP    = 7;
  localparam int HOUR_PM       = 7;
  localparam int IRQ_ALARM_EN  = 3;
  localparam int IRQ_TIMER_EN  = 2;
  // ************************************************************
  // Reset values and timing.
  // ************************************************************
  localparam logic [7:0] RST_ONE  = 8'h01;
  localparam logic [7:0] RST_STAT = 8'h80;
  localparam int OSC_TICKS_PER_SEC = 32768;
endpackage : rtc_pkg

/* File: tb/osc_source.sv */
`timescale 1ns/1ns
// ************************************************************
// Crystal stand-in driving the 32 kHz pin.
// ************************************************************
module osc_source #(
  parameter int HALF_NS = 40
) (
  // Gate from the bench.
  input  wire logic enable,
  // Oscillator pin.
  output logic      osc_out
);
  // A stopped crystal rests low rather than freezing mid-cycle.
  initial osc_out = 1'b0;
  always begin
    #(HALF_NS);
    osc_out = enable ? ~osc_out : 1'b0;
  end
endmodule : osc_source

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  // ************************************************************
  // Stimulus signals and design hookup.
  // ************************************************************
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        osc_en    = 1'b1;
  logic        osc_32k;
  logic [7:0]  reg_addr  = 8'h00;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_rdata, d, s0;
  logic        reg_rd_valid, alarm_irq_n, periodic_irq;
  int          err_total = 0, n_tests = 0, seed = 27, n_tick = 0, v, n0;
  logic [47:0] start_t [4] = '{48'h595923311299, 48'h595923280201,
                               48'h595923280204, 48'h595923300420};
  logic [47:0] exp_t [4]   = '{48'h000000010100, 48'h000000010301,
                               48'h000000290204, 48'h000000010520};
  osc_source osc_source_i (.enable(osc_en), .osc_out(osc_32k));
  bcd_calendar_rtc #(.TICKS_PER_SEC(4)) bcd_calendar_rtc_i (
    .core_clk(core_clk), .rst_n(rst_n), .osc_32k(osc_32k),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .alarm_irq_n(alarm_irq_n),
    .periodic_irq(periodic_irq));
  // Free-running 125 MHz clock.
  always #4 core_clk = ~core_clk;
  // Periodic pulses last one cycle, so they are counted, not sampled.
  always @(posedge core_clk) if (periodic_irq === 1'b1) n_tick <= n_tick + 1;
  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10) * 16 + x % 10);
  endfunction : bcd
  function automatic logic [7:0] rst_val(input int i);
    return (i == 3 || i == 4 || i == 10 || i == 11) ? 8'h01 :
           (i == 14) ? 8'h80 : 8'h00;
  endfunction : rst_val
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: reg %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: pin %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(negedge core_clk);
    chk1(reg_rd_valid, 1'b1);
    r = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk8(d, exp);
  endtask : rchk
  // Freeze first, and let the freeze land, so no tick races the writes.
  task automatic set_time(input logic [47:0] t);
    wr(rtc_pkg::OFF_CTRL, 8'h00);
    repeat (20) @(posedge core_clk);
    for (int k = 0; k < 6; k++) wr(8'(8'h1c + k), t[47-8*k -: 8]);
  endtask : set_time
  task automatic wait_sec();
    logic [7:0] s;
    rd(rtc_pkg::OFF_SEC, s0);
    s = s0;
    for (int i = 0; i < 100 && s === s0; i++) rd(rtc_pkg::OFF_SEC, s);
  endtask : wait_sec
  // ************************************************************
  // Main sequence and watchdog.
  // ************************************************************
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rchk(8'(8'h1c + i), rst_val(i));
    rchk(8'h10, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = $unsigned($random(seed)) % 60;
      wr(8'(8'h23 + i % 2), bcd(v));
      rchk(8'(8'h23 + i % 2), bcd(v));
      v = $unsigned($random(seed)) % 7;
      wr(rtc_pkg::OFF_WDAY, 8'(v));
      rchk(rtc_pkg::OFF_WDAY, 8'(v));
    end
    wr(rtc_pkg::OFF_A_MIN, 8'hd9);
    rchk(rtc_pkg::OFF_A_MIN, 8'h59);
    wr(rtc_pkg::OFF_COMP_L, 8'hff);
    wr(rtc_pkg::OFF_COMP_H, 8'hff);
    wr(rtc_pkg::OFF_CTRL, 8'h60);
    rchk(rtc_pkg::OFF_CTRL, 8'h00);
    wr(rtc_pkg::OFF_CTRL, 8'h1c);
    rchk(rtc_pkg::OFF_CTRL, 8'h1c);
    set_time(48'h000013010100);
    wr(rtc_pkg::OFF_CTRL, 8'h08);
    rchk(rtc_pkg::OFF_HOUR, 8'h81);
    wr(rtc_pkg::OFF_HOUR, 8'h92);
    wr(rtc_pkg::OFF_CTRL, 8'h00);
    rchk(rtc_pkg::OFF_HOUR, 8'h12);
    // Every corner below rolls the day over once: one daily pulse each.
    wr(rtc_pkg::OFF_IRQ_EN, 8'h07);
    for (int c = 0; c < 4; c++) begin
      set_time(start_t[c]);
      wr(rtc_pkg::OFF_CTRL, 8'h01);
      wait_sec();
      for (int k = 0; k < 6; k++)
        rchk(8'(8'h1c + k), exp_t[c][47-8*k -: 8]);
    end
    chk1(n_tick == 4, 1'b1);
    set_time(48'h451000010100);
    wr(rtc_pkg::OFF_CTRL, 8'h03);
    rchk(rtc_pkg::OFF_CTRL, 8'h03);
    wait_sec();
    rchk(rtc_pkg::OFF_SEC, 8'h00);
    rchk(rtc_pkg::OFF_MIN, 8'h11);
    rchk(rtc_pkg::OFF_CTRL, 8'h01);
    // Latch the time well before the next tick, then let a second pass.
    wr(rtc_pkg::OFF_CTRL, 8'h41);
    rchk(rtc_pkg::OFF_CTRL, 8'h01);
    repeat (60) @(posedge core_clk);
    rchk(rtc_pkg::OFF_SEC, 8'h00);
    set_time(48'h100000010100);
    for (int k = 0; k < 6; k++) wr(8'(8'h23 + k), 8'h00);
    wr(rtc_pkg::OFF_A_SEC, 8'h11);
    wr(rtc_pkg::OFF_A_DAY, 8'h01);
    wr(rtc_pkg::OFF_A_MON, 8'h01);
    wr(rtc_pkg::OFF_IRQ_EN, 8'h0c);
    n0 = n_tick;
    wr(rtc_pkg::OFF_CTRL, 8'h01);
    for (int i = 0; i < 300 && alarm_irq_n !== 1'b0; i++) @(posedge core_clk);
    chk1(alarm_irq_n, 1'b0);
    rd(rtc_pkg::OFF_STAT, d);
    chk8(d & 8'h46, 8'h46);
    chk1(n_tick > n0, 1'b1);
    wr(rtc_pkg::OFF_STAT, 8'h40);
    repeat (3) @(posedge core_clk);
    chk1(alarm_irq_n, 1'b1);
    wr(rtc_pkg::OFF_STAT, 8'h80);
    rd(rtc_pkg::OFF_STAT, d);
    chk8(d & 8'h80, 8'h00);
    test_done();
  end
  // A hang counts as a failure and still reaches the verdict.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule : tb_top
